/* hw/bam_compare.v */
// Purpose : one breakpoint comparator, pure combinational
// Assumes : access bytes given as start address and length code
// Notes   : instantiated once per breakpoint by the top
`timescale 1ns/100ps
`include "bam_map.vh"

module bam_compare (
   input  wire [31:0] watch_addr_i,
   input  wire [1:0]  access_type_code_i,
   input  wire [1:0]  range_length_code_i,
   input  wire        debug_ext_enable_i,
   input  wire [1:0]  acc_kind_i,
   input  wire [31:0] acc_addr_i,
   input  wire [1:0]  acc_len_i,
   input  wire        acc_first_i,
   output reg         match_o
);

   reg  [31:0] wmask;
   reg  [1:0]  wlast;
   reg  [1:0]  alast;
   reg  [32:0] w_lo;
   reg  [32:0] w_hi;
   reg  [32:0] a_lo;
   reg  [32:0] a_hi;
   reg         overlap;
   reg         kind_ok;

   // byte ranges, their overlap and kind qualification
   always @* begin
      // RULE_01 RULE_05 length code masks low bits
      wmask = 32'hffff_ffff;
      wlast = 2'h0;
      if (range_length_code_i == `BAM_LEN_TWO) begin
         wmask = 32'hffff_fffe;
         wlast = 2'h1;
      end else if (range_length_code_i == `BAM_LEN_FOUR) begin
         wmask = 32'hffff_fffc;
         wlast = 2'h3;
      end
      alast = 2'h0;
      if (acc_len_i == `BAM_LEN_TWO) begin
         alast = 2'h1;
      end else if (acc_len_i == `BAM_LEN_FOUR) begin
         alast = 2'h3;
      end
      // RULE_04 range starts at aligned watch address
      w_lo = {1'b0, watch_addr_i & wmask};
      w_hi = w_lo + {31'h0, wlast};
      a_lo = {1'b0, acc_addr_i};
      a_hi = a_lo + {31'h0, alast}; // 33 bits, no wrap at top
      // RULE_07 any accessed byte inside range
      overlap = (a_lo <= w_hi) && (w_lo <= a_hi);
      // RULE_11 access type select
      case (access_type_code_i)
         `BAM_TYPE_EXEC: begin
            // RULE_08 first byte only
            kind_ok = (acc_kind_i == `BAM_ACC_FETCH) && acc_first_i &&
                      (watch_addr_i == acc_addr_i);
         end
         `BAM_TYPE_WRITE: begin
            kind_ok = (acc_kind_i == `BAM_ACC_WRITE) && overlap;
         end
         `BAM_TYPE_IO: begin
            kind_ok = debug_ext_enable_i && (acc_kind_i == `BAM_ACC_IO) && overlap;
         end
         default: begin
            kind_ok = ((acc_kind_i == `BAM_ACC_READ) ||
                       (acc_kind_i == `BAM_ACC_WRITE)) && overlap;
         end
      endcase
      match_o = kind_ok;
   end

endmodule

/* hw/bam_map.vh */
// Purpose : constants for the breakpoint address match block
// Assumes : included by the match top and its comparator
// Notes   : register offsets are word indexes on the plain register port
`ifndef BAM_MAP_VH
`define BAM_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define BAM_ADDR_W        4'd4
`define BAM_OFF_WATCH0    4'h0
`define BAM_OFF_WATCH1    4'h1
`define BAM_OFF_WATCH2    4'h2
`define BAM_OFF_WATCH3    4'h3
`define BAM_OFF_STATUS    4'h6
`define BAM_OFF_CONTROL   4'h7
`define BAM_OFF_CONFIG    4'h8
`define BAM_OFF_IRQ_STAT  4'h9
`define BAM_OFF_IRQ_MASK  4'ha

// ----------------------------------------------------------------
// control register field positions
// ----------------------------------------------------------------
`define BAM_CTL_LOCAL_EN(n)  (2*(n))
`define BAM_CTL_ALL_EN(n)    (2*(n)+1)
`define BAM_CTL_TYPE_LO(n)   (16+4*(n))
`define BAM_CTL_LEN_LO(n)    (18+4*(n))

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define BAM_TYPE_EXEC     2'h0
`define BAM_TYPE_WRITE    2'h1
`define BAM_TYPE_IO       2'h2
`define BAM_TYPE_RW       2'h3
`define BAM_LEN_ONE       2'h0
`define BAM_LEN_TWO       2'h1
`define BAM_LEN_FOUR      2'h3
`define BAM_ACC_FETCH     2'h0
`define BAM_ACC_READ      2'h1
`define BAM_ACC_WRITE     2'h2
`define BAM_ACC_IO        2'h3

// ----------------------------------------------------------------
// reset values and vectors
// ----------------------------------------------------------------
`define BAM_RST_WORD      32'h0000_0000
`define BAM_RST_STATUS    32'hffff_0ff0
`define BAM_RST_CONTROL   32'h0000_0400
`define BAM_VEC_DEBUG     8'h01
`define BAM_VEC_BRK_INSTR 8'h03

`endif

/* hw/bam_match.v */
// Purpose : four-breakpoint linear address match with status and interrupt
// Assumes : one clock, synchronous reset, plain register port
// Notes   : access port is qualified by acc_valid_i, same clock domain
//
// Function
// RULE_01: length code 00 one byte, 01 two, 11 four, 10 undefined.
// RULE_02: length codes at control bits 19:18, 23:22, 27:26, 31:30.
// RULE_03: software sets length 00 for execute breakpoints.
// RULE_04: data and I/O ranges start at watch address, naturally aligned.
// RULE_05: length code masks low watch address bits for alignment.
// RULE_06: I/O port address zero-extended from 16 to 32 bits.
// RULE_07: data hit when any accessed byte lies in the range.
// RULE_08: execute hit only on an instruction's first byte.
// RULE_09: software may pair byte breakpoints to cover unaligned operands.
// RULE_10: debug exception uses vector 1; vector 3 is breakpoint instruction.
// RULE_11: type 00 exec, 01 write, 11 read/write, 10 I/O if extensions on.
// RULE_12: exception raised only if local or global enable set.
// RULE_13: on exception all satisfied hit flags are set, even disabled.
// RULE_14: comparisons use linear addresses before translation.
// RULE_15: four breakpoints evaluated in parallel, each reports own hit.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "bam_map.vh"

module bam_match (
   input  wire        clk_i,
   input  wire        reset_i,
   input  wire        clk_en_i,
   input  wire [3:0]  reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output reg  [31:0] reg_rdata_o,
   input  wire        acc_valid_i,
   input  wire [1:0]  acc_kind_i,
   input  wire [31:0] acc_lin_addr_i,
   input  wire [15:0] acc_io_port_i,
   input  wire [1:0]  acc_len_i,
   input  wire        acc_first_i,
   output reg  [3:0]  hit_o,
   output reg         debug_fault_o,
   output reg  [7:0]  debug_fault_vector_o,
   output reg         irq_o
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [31:0] watch_address_reg [0:3];
   reg  [31:0] debug_status_reg;
   reg  [31:0] debug_control_reg;
   reg         debug_ext_enable;
   reg  [4:0]  irq_stat;
   reg  [4:0]  irq_mask;
   reg  [31:0] next_rdata;

   wire [3:0]  match;
   wire [3:0]  enabled;
   wire [31:0] cmp_addr;
   wire        raise;

   // RULE_06 zero-extend port address
   assign cmp_addr = (acc_kind_i == `BAM_ACC_IO) ? {16'h0000, acc_io_port_i}
                                                 : acc_lin_addr_i;

   // ----------------------------------------------------------------
   // comparators
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gen_bp
         // RULE_15 parallel comparators
         bam_compare u_cmp (
            .watch_addr_i        (watch_address_reg[g]),
            .access_type_code_i  (debug_control_reg[`BAM_CTL_TYPE_LO(g)+1:
                                                    `BAM_CTL_TYPE_LO(g)]),
            // RULE_02 length field slice
            .range_length_code_i (debug_control_reg[`BAM_CTL_LEN_LO(g)+1:
                                                    `BAM_CTL_LEN_LO(g)]),
            .debug_ext_enable_i  (debug_ext_enable),
            .acc_kind_i          (acc_kind_i),
            .acc_addr_i          (cmp_addr),
            .acc_len_i           (acc_len_i),
            .acc_first_i         (acc_first_i),
            .match_o             (match[g])
         );
         // RULE_12 local or global enable
         assign enabled[g] = debug_control_reg[`BAM_CTL_LOCAL_EN(g)] |
                             debug_control_reg[`BAM_CTL_ALL_EN(g)];
      end
   endgenerate

   // RULE_14 linear address compare
   assign raise = acc_valid_i & |(match & enabled);

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always @* begin
      next_rdata = 32'h0000_0000;
      case (reg_addr_i)
         `BAM_OFF_WATCH0:   next_rdata = watch_address_reg[0];
         `BAM_OFF_WATCH1:   next_rdata = watch_address_reg[1];
         `BAM_OFF_WATCH2:   next_rdata = watch_address_reg[2];
         `BAM_OFF_WATCH3:   next_rdata = watch_address_reg[3];
         `BAM_OFF_STATUS:   next_rdata = debug_status_reg;
         `BAM_OFF_CONTROL:  next_rdata = debug_control_reg;
         `BAM_OFF_CONFIG:   next_rdata = {31'h0000_0000, debug_ext_enable};
         `BAM_OFF_IRQ_STAT: next_rdata = {27'h000_0000, irq_stat};
         `BAM_OFF_IRQ_MASK: next_rdata = {27'h000_0000, irq_mask};
         default:           next_rdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   integer i;
   always @(posedge clk_i) begin
      if (reset_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            watch_address_reg[i] <= `BAM_RST_WORD;
         end
         debug_status_reg     <= `BAM_RST_STATUS;
         debug_control_reg    <= `BAM_RST_CONTROL;
         debug_ext_enable     <= 1'b0;
         irq_stat             <= 5'h00;
         irq_mask             <= 5'h00;
         reg_rdata_o          <= 32'h0000_0000;
         hit_o                <= 4'h0;
         debug_fault_o        <= 1'b0;
         debug_fault_vector_o <= 8'h00;
         irq_o                <= 1'b0;
      end else if (clk_en_i) begin
         // register writes
         if (reg_wr_i) begin
            case (reg_addr_i)
               `BAM_OFF_WATCH0:   watch_address_reg[0] <= reg_wdata_i;
               `BAM_OFF_WATCH1:   watch_address_reg[1] <= reg_wdata_i;
               `BAM_OFF_WATCH2:   watch_address_reg[2] <= reg_wdata_i;
               `BAM_OFF_WATCH3:   watch_address_reg[3] <= reg_wdata_i;
               `BAM_OFF_CONTROL:  debug_control_reg    <= reg_wdata_i;
               `BAM_OFF_CONFIG:   debug_ext_enable     <= reg_wdata_i[0];
               `BAM_OFF_IRQ_MASK: irq_mask             <= reg_wdata_i[4:0];
               default:           ;
            endcase
         end
         // status write first so that hardware set wins below
         if (reg_wr_i && reg_addr_i == `BAM_OFF_STATUS) begin
            debug_status_reg <= reg_wdata_i;
         end
         // RULE_13 hit flags on exception
         if (raise) begin
            debug_status_reg[3:0] <= match;
         end
         // read data one cycle later
         reg_rdata_o <= reg_rd_i ? next_rdata : 32'h0000_0000;
         // sticky interrupt status, read clears, set wins
         if (reg_rd_i && reg_addr_i == `BAM_OFF_IRQ_STAT) begin
            irq_stat <= raise ? {1'b1, match} : 5'h00;
         end else if (raise) begin
            irq_stat <= irq_stat | {1'b1, match};
         end
         irq_o <= |((raise ? (irq_stat | {1'b1, match}) :
                     ((reg_rd_i && reg_addr_i == `BAM_OFF_IRQ_STAT) ? 5'h00 : irq_stat))
                    & irq_mask);
         // per-access hit report
         hit_o <= acc_valid_i ? match : 4'h0;
         debug_fault_o <= raise;
         // RULE_10 debug vector
         debug_fault_vector_o <= raise ? `BAM_VEC_DEBUG : 8'h00;
      end
   end

endmodule

/* verif/bam_access_model.sv */
// Purpose: access path model issuing fetch, data and port accesses
// Assumes: one access per call after a chosen idle gap
// Notes  : address lines scrambled between accesses
`timescale 1ns/100ps
module bam_access_model (
   input  wire        clk_i,
   output reg         acc_valid_o,
   output reg  [1:0]  acc_kind_o,
   output reg  [31:0] acc_lin_addr_o,
   output reg  [15:0] acc_io_port_o,
   output reg  [1:0]  acc_len_o,
   output reg         acc_first_o
);
   initial {acc_valid_o, acc_kind_o, acc_lin_addr_o, acc_io_port_o, acc_len_o, acc_first_o} = 0;
   // one access after g+1 clock edges, held one edge
   task access(input [1:0] k, input [31:0] a, input [1:0] l, input f, input int g);
      repeat (g + 1) @(posedge clk_i);
      {acc_lin_addr_o, acc_io_port_o} <= {a, a[15:0]};
      {acc_valid_o, acc_kind_o, acc_len_o, acc_first_o} <= {1'b1, k, l, f};
      @(posedge clk_i);
      {acc_valid_o, acc_lin_addr_o, acc_io_port_o} <= {1'b0, ~a, ~a[15:0]};
   endtask
endmodule

/* verif/bam_match_assertions.sv */
// Purpose: port checker for the breakpoint match block
// Assumes: single clock; control word seen on the register port
// Notes  : shadows the control word to know each breakpoint type
`timescale 1ns/100ps
`include "bam_map.vh"
module bam_match_checker (
   input wire        clk_i,
   input wire        reset_i,
   input wire        clk_en_i,
   input wire [3:0]  reg_addr_i,
   input wire [31:0] reg_wdata_i,
   input wire        reg_wr_i,
   input wire        acc_valid_i,
   input wire [1:0]  acc_kind_i,
   input wire        acc_first_i,
   input wire [3:0]  hit_o,
   input wire        debug_fault_o,
   input wire [7:0]  debug_fault_vector_o
);
   reg  [31:0] ctl;
   // breakpoints of one type code
   function [3:0] tm(input [31:0] c, input [1:0] t);
      for (int i = 0; i < 4; i++)
         tm[i] = c[16+4*i +: 2] == t;
   endfunction
   wire [3:0]  xm = tm(ctl, 2'h0);
   wire [3:0]  wm = tm(ctl, 2'h1);
   wire [3:0]  im = tm(ctl, 2'h2);
   wire [3:0]  en = {|ctl[7:6], |ctl[5:4], |ctl[3:2], |ctl[1:0]};
   // shadow of the control word
   always @(posedge clk_i)
      if (reset_i)
         ctl <= `BAM_RST_CONTROL;
      else if (clk_en_i && reg_wr_i && reg_addr_i == `BAM_OFF_CONTROL)
         ctl <= reg_wdata_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i || !clk_en_i);
   property p_vec; debug_fault_vector_o == (debug_fault_o ? 8'h01 : 8'h00); endproperty
   a_vec: assert property (p_vec) else $error("fault vector wrong");
   property p_idle; !acc_valid_i |=> hit_o == 4'h0 && !debug_fault_o; endproperty
   a_idle: assert property (p_idle) else $error("hit without access");
   property p_fault; acc_valid_i |=> debug_fault_o == |(hit_o & $past(en)); endproperty
   a_fault: assert property (p_fault) else $error("fault enable wrong");
   property p_first; acc_valid_i && acc_kind_i == 2'h0 && !acc_first_i |=> hit_o == 4'h0; endproperty
   a_first: assert property (p_first) else $error("later byte hit");
   property p_dexec; acc_valid_i && acc_kind_i != 2'h0 |=> (hit_o & $past(xm)) == 4'h0; endproperty
   a_dexec: assert property (p_dexec) else $error("data hit on exec");
   property p_fetch; acc_valid_i && acc_kind_i == 2'h0 |=> (hit_o & ~$past(xm)) == 4'h0; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch hit on data");
   property p_wonly; acc_valid_i && acc_kind_i == 2'h1 |=> (hit_o & $past(wm)) == 4'h0; endproperty
   a_wonly: assert property (p_wonly) else $error("read hit on write");
   property p_io; acc_valid_i && acc_kind_i != 2'h3 |=> (hit_o & $past(im)) == 4'h0; endproperty
   a_io: assert property (p_io) else $error("memory hit on port");
   c_multi: cover property (acc_valid_i ##1 $countones(hit_o) > 1);
   c_fault: cover property (debug_fault_o);
   c_port: cover property (acc_valid_i && acc_kind_i == 2'h3 ##1 hit_o != 4'h0);
endmodule
bind bam_match bam_match_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .acc_valid_i(acc_valid_i), .acc_kind_i(acc_kind_i), .acc_first_i(acc_first_i),
   .hit_o(hit_o), .debug_fault_o(debug_fault_o), .debug_fault_vector_o(debug_fault_vector_o));

/* verif/test_breakpoint_address_match.sv */
// Purpose: self-checking bench for the breakpoint match block
// Assumes: access model drives the fetch and load/store port
// Notes  : expected hits come from a byte range model per breakpoint
`timescale 1ns/100ps
`include "bam_map.vh"
module test_breakpoint_address_match;
   reg         clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, de = 0, clk_en = 1;
   reg  [3:0]  reg_addr_i = 4'h0;
   reg  [31:0] reg_wdata_i = 32'h0, ctl = `BAM_RST_CONTROL, wa [0:3];
   reg  [1:0]  ty [0:3], ln [0:3];
   wire        acc_valid, acc_first, debug_fault_o, irq_o;
   wire [1:0]  acc_kind, acc_len;
   wire [3:0]  hit_o;
   wire [7:0]  debug_fault_vector_o;
   wire [15:0] acc_port;
   wire [31:0] acc_addr, reg_rdata_o;
   int         n_errors = 0, check_count = 0;
   bam_access_model u_model (.clk_i(clk_i), .acc_valid_o(acc_valid), .acc_kind_o(acc_kind),
      .acc_lin_addr_o(acc_addr), .acc_io_port_o(acc_port), .acc_len_o(acc_len),
      .acc_first_o(acc_first));
   bam_match u_dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .acc_valid_i(acc_valid), .acc_kind_i(acc_kind),
      .acc_lin_addr_i(acc_addr), .acc_io_port_i(acc_port), .acc_len_i(acc_len),
      .acc_first_i(acc_first), .hit_o(hit_o), .debug_fault_o(debug_fault_o),
      .debug_fault_vector_o(debug_fault_vector_o), .irq_o(irq_o));
   initial forever #50 clk_i = ~clk_i;
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input [3:0] a, input [31:0] d);
      @(posedge clk_i);
      {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task rd(input [3:0] a, input [31:0] e);
      @(posedge clk_i);
      {reg_rd_i, reg_addr_i} <= {1'b1, a};
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, e);
   endtask
   task wirq(input v);
      for (int n = 0; n < 4 && irq_o !== v; n++)
         @(posedge clk_i) #1;
      chk(irq_o, v);
      if (irq_o !== v)
         end_of_test;
   endtask
   task cfg(input int i, input [31:0] a, input [1:0] t, input [1:0] l, input e);
      {wa[i], ty[i], ln[i]} = {a, t, l};
      ctl[2*i +: 2] = {e & i[0], e & !i[0]};
      {ctl[18+4*i +: 2], ctl[16+4*i +: 2]} = {l, t};
      wr(i[3:0], a);
      wr(`BAM_OFF_CONTROL, ctl);
   endtask
   function [3:0] exp_hit(input [1:0] k, input [31:0] a, input [1:0] l, input f);
      reg [31:0] sz, lo, ea;
      ea = (k == `BAM_ACC_IO) ? {16'h0, a[15:0]} : a;
      for (int i = 0; i < 4; i++) begin
         sz = (ln[i] == `BAM_LEN_FOUR) ? 4 : (ln[i] == `BAM_LEN_TWO) ? 2 : 1;
         lo = wa[i] & ~(sz - 1);
         exp_hit[i] = (ty[i] == `BAM_TYPE_EXEC) ? (k == `BAM_ACC_FETCH && f && a == wa[i]) :
            ea < lo + sz && lo < ea + (l == 2'h3 ? 4 : l + 1) && (ty[i] == `BAM_TYPE_IO ?
            k == `BAM_ACC_IO && de : k == `BAM_ACC_WRITE || ty[i] == 2'h3 && k == 2'h1);
      end
   endfunction
   task acc(input [1:0] k, input [31:0] a, input [1:0] l, input f, input int g);
      reg [3:0] e;
      reg       x;
      e = exp_hit(k, a, l, f);
      x = |(e & {|ctl[7:6], |ctl[5:4], |ctl[3:2], |ctl[1:0]});
      u_model.access(k, a, l, f, g);
      #1 chk(hit_o, e);
      chk(debug_fault_o, x);
      chk(debug_fault_vector_o, x ? 8'h01 : 8'h00);
   endtask
   task t_reset;
      rd(`BAM_OFF_STATUS, `BAM_RST_STATUS);
      rd(`BAM_OFF_CONTROL, `BAM_RST_CONTROL);
      wr(4'hf, 32'h1234_5678);
      rd(4'hf, 32'h0);
      rd(`BAM_OFF_WATCH3, 32'h0);
      // frozen clock enable drops a write
      @(posedge clk_i);
      clk_en <= 1'b0;
      wr(`BAM_OFF_WATCH0, 32'h5a5a_0001);
      @(posedge clk_i);
      clk_en <= 1'b1;
      rd(`BAM_OFF_WATCH0, 32'h0);
   endtask
   task t_table;
      reg [35:0] tb [0:13];
      tb = '{36'h4000a0001, 36'h9000a0000, 36'h8000a0002, 36'h4000a0002, 36'h9000a0002,
         36'h7000b0000, 36'h5000b0000, 36'hb000c0000, 36'h9000c0002, 36'h7000c0000,
         36'hb000c0004, 36'h8000a0003, 36'h0000a0001, 36'hb000a0000};
      wr(`BAM_OFF_CONFIG, 32'h1);
      de = 1'b1;
      cfg(0, 32'h000a_0001, `BAM_TYPE_RW, `BAM_LEN_ONE, 1'b1);
      cfg(1, 32'h000a_0002, `BAM_TYPE_WRITE, `BAM_LEN_ONE, 1'b1);
      cfg(2, 32'h000b_0002, `BAM_TYPE_RW, `BAM_LEN_TWO, 1'b1);
      cfg(3, 32'h000c_0000, `BAM_TYPE_WRITE, `BAM_LEN_FOUR, 1'b1);
      for (int i = 0; i < 14; i++)
         acc(tb[i][35:34], tb[i][31:0], tb[i][33:32], 1'b1, i % 3);
      rd(`BAM_OFF_IRQ_STAT, 32'h1f);
      chk(irq_o, 1'b0);
   endtask
   task t_exec;
      wr(`BAM_OFF_IRQ_MASK, 32'h1);
      cfg(0, 32'h0000_1230, `BAM_TYPE_EXEC, `BAM_LEN_ONE, 1'b1);
      cfg(1, 32'h0000_1230, `BAM_TYPE_EXEC, `BAM_LEN_ONE, 1'b0);
      acc(`BAM_ACC_FETCH, 32'h1230, 2'h0, 1'b1, 0);
      wirq(1'b1);
      acc(`BAM_ACC_FETCH, 32'h1230, 2'h0, 1'b0, 1);
      acc(`BAM_ACC_FETCH, 32'h1231, 2'h0, 1'b1, 0);
      acc(`BAM_ACC_READ, 32'h1230, 2'h0, 1'b1, 0);
      rd(`BAM_OFF_STATUS, 32'hffff_0ff3);
      rd(`BAM_OFF_IRQ_STAT, 32'h13);
      wirq(1'b0);
   endtask
   task t_pair;
      cfg(0, 32'h0000_2003, `BAM_TYPE_RW, `BAM_LEN_ONE, 1'b1);
      cfg(1, 32'h0000_2004, `BAM_TYPE_RW, `BAM_LEN_ONE, 1'b1);
      acc(`BAM_ACC_READ, 32'h2003, 2'h1, 1'b1, 0);
      acc(`BAM_ACC_WRITE, 32'h2000, 2'h3, 1'b1, 1);
      acc(`BAM_ACC_READ, 32'h2005, 2'h0, 1'b1, 0);
      acc(`BAM_ACC_WRITE, 32'h2002, 2'h0, 1'b1, 0);
      rd(`BAM_OFF_STATUS, 32'hffff_0ff1);
      rd(`BAM_OFF_IRQ_STAT, 32'h17);
   endtask
   task t_io;
      cfg(2, 32'h0000_0081, `BAM_TYPE_IO, `BAM_LEN_TWO, 1'b1);
      cfg(3, 32'h0001_0080, `BAM_TYPE_IO, `BAM_LEN_ONE, 1'b1);
      acc(`BAM_ACC_IO, 32'h0000_0080, 2'h0, 1'b1, 0);
      acc(`BAM_ACC_IO, 32'h0001_0080, 2'h0, 1'b1, 2);
      wr(`BAM_OFF_CONFIG, 32'h0);
      de = 1'b0;
      acc(`BAM_ACC_IO, 32'h0000_0080, 2'h0, 1'b1, 0);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      reset_i <= 1'b0;
      t_reset;
      t_table;
      t_exec;
      t_io;
      t_pair;
      end_of_test;
   end
endmodule
